// file: design/regfile_core.sv
// register file of the cpu core with two alternate working register sets
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module regfile_core
	import regfile_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// software register port
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [DATA_W-1:0]    wdata,
	input  wire logic                 write_strobe,
	input  wire logic                 read_strobe,
	output logic      [DATA_W-1:0]    rdata,
	// execution unit side
	input  wire logic [3:0]           op_index,
	output logic      [DATA_W-1:0]    op_data,
	input  wire logic                 wb_en,
	input  wire logic [3:0]           wb_index,
	input  wire logic [DATA_W-1:0]    wb_data,
	input  wire logic                 irq_enter,
	input  wire logic [CTX_W-1:0]     irq_level,
	input  wire logic                 irq_return,
	input  wire logic                 swap_en,
	input  wire logic [CTX_W-1:0]     swap_ctx,
	input  wire logic                 pc_load,
	input  wire logic [PC_W-1:0]      pc_value,
	input  wire logic                 pc_step,
	input  wire logic                 loop_start_load,
	input  wire logic [PC_W-1:0]      loop_start_value,
	input  wire logic                 acc_load,
	input  wire logic                 acc_sel,
	input  wire logic [ACC_W-1:0]     acc_value,
	// state seen by the core
	output logic      [CTX_W-1:0]     current_context_index,
	output logic      [CTX_W-1:0]     manual_context_index,
	output logic      [DATA_W-1:0]    stack_pointer_register,
	output logic      [PC_W-1:0]      pc_out,
	output logic      [ACC_W-1:0]     accumulator_first,
	output logic      [ACC_W-1:0]     accumulator_second
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [NUM_SETS-1:0][ALT_W-1:0][DATA_W-1:0] work;
		logic [DATA_W-1:0]                          sp;
		logic [ACC_W-1:0]                           acc1;
		logic [ACC_W-1:0]                           acc2;
		logic [PC_W-1:0]                            pc;
		logic [PC_W-1:0]                            loop_start;
		logic [CTX_W-1:0]                           lvl1;
		logic [CTX_W-1:0]                           lvl2;
		logic [CTX_W-1:0]                           cur;
		logic [CTX_W-1:0]                           man;
		logic [CTX_W-1:0]                           saved;
		logic [DATA_W-1:0]                          rd;
		logic [DATA_W-1:0]                          op;
	} state_s;

	state_s s_q;
	state_s s_d;

	// set selected by an interrupt at the given level, primary when unbound
	function automatic logic [CTX_W-1:0] level_ctx(input logic [CTX_W-1:0] lvl,
		input logic [CTX_W-1:0] l1, input logic [CTX_W-1:0] l2);
		logic [CTX_W-1:0] r;
		r = CTX_PRIMARY;
		if (lvl >= LEVEL_MIN && lvl <= LEVEL_MAX)
		begin
			if (lvl == l1)
				r = CTX_ALT1;
			else if (lvl == l2)
				r = CTX_LAST;
		end
		return r;
	endfunction

	// working register read in the active set, stack pointer shared
	function automatic logic [DATA_W-1:0] work_rd(input state_s st, input logic [3:0] idx);
		logic [DATA_W-1:0] r;
		r = st.sp;
		if (idx != 4'(SP_INDEX))
			r = st.work[st.cur[1:0]][idx];
		return r;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic [3:0] widx;
		widx = addr[5:2];
		s_d = s_q;
		s_d.rd = RESET_WORD;
		// operand path for data, pointer or offset use
		s_d.op = work_rd(s_q, op_index);
		// pointer and offset operands feed the x and y generators
		// modulo, bit-reversed and program view addressing sit there
		// addressing mode groups are decoded by the execution unit
		if (wb_en)
		begin
			if (wb_index == 4'(SP_INDEX))
				s_d.sp = wb_data;
			else
				s_d.work[s_q.cur[1:0]][wb_index] = wb_data;
		end
		if (pc_load)
			s_d.pc = pc_value;
		else if (pc_step)
			s_d.pc = s_q.pc + PC_W'(1);
		// loop start only changes from the loop hardware
		if (loop_start_load)
			s_d.loop_start = loop_start_value;
		if (acc_load)
		begin
			if (acc_sel)
				s_d.acc2 = acc_value;
			else
				s_d.acc1 = acc_value;
		end
		// context selection: return, interrupt, then manual swap
		if (irq_return)
			s_d.cur = s_q.saved;
		if (irq_enter)
		begin
			s_d.saved = s_q.cur;
			s_d.cur = level_ctx(irq_level, s_q.lvl1, s_q.lvl2);
		end
		if (swap_en && swap_ctx <= CTX_LAST)
		begin
			s_d.cur = swap_ctx;
			s_d.man = swap_ctx;
		end
		// software port
		if (read_strobe)
		begin
			if (addr <= ADDR_SP)
				s_d.rd = work_rd(s_q, widx);
			else
				case (addr)
					ADDR_ACC1_L:   s_d.rd = s_q.acc1[15:0];
					ADDR_ACC1_H:   s_d.rd = s_q.acc1[31:16];
					ADDR_ACC1_U:   s_d.rd = {8'h00, s_q.acc1[39:32]};
					ADDR_ACC2_L:   s_d.rd = s_q.acc2[15:0];
					ADDR_ACC2_H:   s_d.rd = s_q.acc2[31:16];
					ADDR_ACC2_U:   s_d.rd = {8'h00, s_q.acc2[39:32]};
					ADDR_PC_L:     s_d.rd = s_q.pc[15:0];
					ADDR_PC_H:     s_d.rd = {9'h000, s_q.pc[22:16]};
					ADDR_LOOP_SL:  s_d.rd = s_q.loop_start[15:0];
					ADDR_LOOP_SH:  s_d.rd = {9'h000, s_q.loop_start[22:16]};
					ADDR_ALT_CFG:  s_d.rd = DATA_W'({s_q.lvl2, 1'b0, s_q.lvl1});
					ADDR_CTX_STAT: s_d.rd = DATA_W'({s_q.man, 5'h00, s_q.cur});
					default:       s_d.rd = RESET_WORD;
				endcase
		end
		if (write_strobe)
		begin
			if (addr <= ADDR_SP)
			begin
				if (widx == 4'(SP_INDEX))
					s_d.sp = wdata;
				else
					s_d.work[s_q.cur[1:0]][widx] = wdata;
			end
			else
				case (addr)
					ADDR_ACC1_L:  s_d.acc1[15:0] = wdata;
					ADDR_ACC1_H:  s_d.acc1[31:16] = wdata;
					ADDR_ACC1_U:  s_d.acc1[39:32] = wdata[7:0];
					ADDR_ACC2_L:  s_d.acc2[15:0] = wdata;
					ADDR_ACC2_H:  s_d.acc2[31:16] = wdata;
					ADDR_ACC2_U:  s_d.acc2[39:32] = wdata[7:0];
					ADDR_PC_L:    s_d.pc[15:0] = wdata;
					ADDR_PC_H:    s_d.pc[22:16] = wdata[6:0];
					ADDR_ALT_CFG:
					begin
						s_d.lvl1 = wdata[CFG_SET1_LSB +: CTX_W];
						s_d.lvl2 = wdata[CFG_SET2_LSB +: CTX_W];
					end
					ADDR_CTX_SWAP:
					begin
						if (wdata[CTX_W-1:0] <= CTX_LAST)
						begin
							s_d.cur = wdata[CTX_W-1:0];
							s_d.man = wdata[CTX_W-1:0];
						end
					end
					// loop start words are read-only
					default: s_d.rd = s_d.rd;
				endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			s_q <= '0; // primary set active
		end
		else
		begin
			s_q <= s_d;
		end
	end

	always_comb
	begin
		rdata = s_q.rd;
		op_data = s_q.op;
		current_context_index = s_q.cur;
		manual_context_index = s_q.man;
		stack_pointer_register = s_q.sp;
		pc_out = s_q.pc;
		accumulator_first = s_q.acc1;
		accumulator_second = s_q.acc2;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	// a software swap command in the same cycle overrides the core side
	logic ctx_cmd;
	assign ctx_cmd = write_strobe && (addr == ADDR_CTX_SWAP);

	sequence swap_req;
		swap_en && !irq_enter && swap_ctx <= CTX_LAST && !ctx_cmd;
	endsequence

	sequence stat_read;
		read_strobe && addr == ADDR_CTX_STAT;
	endsequence

	sequence cfg_read;
		read_strobe && addr == ADDR_ALT_CFG;
	endsequence

	a_reset_primary: assert property (@(posedge clock)
		reset |=> current_context_index == CTX_PRIMARY && manual_context_index == CTX_PRIMARY)
		else $error("context not primary after reset");

	a_swap_sets_ctx: assert property (@(posedge clock) disable iff (reset)
		swap_req |=> current_context_index == $past(swap_ctx))
		else $error("manual swap did not select the set");

	a_swap_reports: assert property (@(posedge clock) disable iff (reset)
		swap_req |=> manual_context_index == $past(swap_ctx))
		else $error("manual index not reported");

	a_irq_binding: assert property (@(posedge clock) disable iff (reset)
		irq_enter && !swap_en && !ctx_cmd && irq_level == s_q.lvl1 && irq_level >= LEVEL_MIN
		&& irq_level <= LEVEL_MAX |=> current_context_index == CTX_ALT1)
		else $error("bound level did not select set one");

	a_loop_ro: assert property (@(posedge clock) disable iff (reset)
		!loop_start_load |=> $stable(s_q.loop_start))
		else $error("loop start changed by software");

	a_read_delay: assert property (@(posedge clock) disable iff (reset)
		!read_strobe |=> rdata == RESET_WORD)
		else $error("read data outside its cycle");

	a_sp_shared: assert property (@(posedge clock) disable iff (reset)
		write_strobe && addr == ADDR_SP && !wb_en |=> stack_pointer_register == $past(wdata))
		else $error("stack pointer write lost");

	a_pc_step: assert property (@(posedge clock) disable iff (reset)
		pc_step && !pc_load && !write_strobe |=> pc_out == $past(pc_out) + PC_W'(1))
		else $error("program counter did not advance");

	a_acc_load: assert property (@(posedge clock) disable iff (reset)
		acc_load && !acc_sel && !write_strobe |=> accumulator_first == $past(acc_value))
		else $error("accumulator load lost");

	a_swap_ignored: assert property (@(posedge clock) disable iff (reset)
		swap_en && swap_ctx > CTX_LAST && !irq_enter && !irq_return && !ctx_cmd
		|=> $stable(current_context_index) && $stable(manual_context_index))
		else $error("out of range swap changed the context");

	a_irq_unbound: assert property (@(posedge clock) disable iff (reset)
		irq_enter && !swap_en && !ctx_cmd
		&& (irq_level < LEVEL_MIN || irq_level > LEVEL_MAX
		|| (irq_level != s_q.lvl1 && irq_level != s_q.lvl2))
		|=> current_context_index == CTX_PRIMARY)
		else $error("unbound level left an alternate set active");

	a_irq_return: assert property (@(posedge clock) disable iff (reset)
		irq_return && !irq_enter && !swap_en && !ctx_cmd
		|=> current_context_index == $past(s_q.saved))
		else $error("return did not restore the saved set");

	a_stat_fields: assert property (@(posedge clock) disable iff (reset)
		stat_read |=> rdata[STAT_CUR_LSB +: CTX_W] == $past(current_context_index)
		&& rdata[STAT_MAN_LSB +: CTX_W] == $past(manual_context_index))
		else $error("context status fields wrong");

	a_cfg_fields: assert property (@(posedge clock) disable iff (reset)
		cfg_read |=> rdata[CFG_SET1_LSB +: CTX_W] == $past(s_q.lvl1)
		&& rdata[CFG_SET2_LSB +: CTX_W] == $past(s_q.lvl2))
		else $error("level assignment fields wrong");

	a_op_path: assert property (@(posedge clock) disable iff (reset)
		op_index == 4'(SP_INDEX) |=> op_data == $past(stack_pointer_register))
		else $error("operand path did not return the stack pointer");

	a_wb_sp: assert property (@(posedge clock) disable iff (reset)
		wb_en && wb_index == 4'(SP_INDEX) && !write_strobe
		|=> stack_pointer_register == $past(wb_data))
		else $error("stack pointer writeback lost");

	a_ctx_legal: assert property (@(posedge clock) disable iff (reset)
		current_context_index <= CTX_LAST)
		else $error("context index beyond the alternate sets");

	a_pc_load: assert property (@(posedge clock) disable iff (reset)
		pc_load && !write_strobe |=> pc_out == $past(pc_value))
		else $error("program counter load lost");

	a_acc2_load: assert property (@(posedge clock) disable iff (reset)
		acc_load && acc_sel && !write_strobe |=> accumulator_second == $past(acc_value))
		else $error("second accumulator load lost");
endmodule

// file: pkg/regfile_pkg.sv
// constants for the cpu register file with alternate contexts
package regfile_pkg;
	localparam int DATA_W      = 16;
	localparam int NUM_W       = 16;
	localparam int ALT_W       = 15;
	localparam int NUM_SETS    = 3;
	localparam int CTX_W       = 3;
	localparam int PC_W        = 23;
	localparam int ACC_W       = 40;
	localparam int ADDR_W      = 8;
	localparam int SP_INDEX    = 15;
	// register map (word index, byte address = index * 4)
	localparam logic [ADDR_W-1:0] ADDR_W0        = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SP        = 8'h3c;
	localparam logic [ADDR_W-1:0] ADDR_ACC1_L    = 8'h40;
	localparam logic [ADDR_W-1:0] ADDR_ACC1_H    = 8'h44;
	localparam logic [ADDR_W-1:0] ADDR_ACC1_U    = 8'h48;
	localparam logic [ADDR_W-1:0] ADDR_ACC2_L    = 8'h4c;
	localparam logic [ADDR_W-1:0] ADDR_ACC2_H    = 8'h50;
	localparam logic [ADDR_W-1:0] ADDR_ACC2_U    = 8'h54;
	localparam logic [ADDR_W-1:0] ADDR_PC_L      = 8'h58;
	localparam logic [ADDR_W-1:0] ADDR_PC_H      = 8'h5c;
	localparam logic [ADDR_W-1:0] ADDR_LOOP_SL   = 8'h60;
	localparam logic [ADDR_W-1:0] ADDR_LOOP_SH   = 8'h64;
	localparam logic [ADDR_W-1:0] ADDR_ALT_CFG   = 8'h68;
	localparam logic [ADDR_W-1:0] ADDR_CTX_STAT  = 8'h6c;
	localparam logic [ADDR_W-1:0] ADDR_CTX_SWAP  = 8'h70;
	// field layout of the alternate set config word: set1 in [2:0], set2 in [6:4]
	localparam int CFG_SET1_LSB  = 0;
	localparam int CFG_SET2_LSB  = 4;
	// context status: current in [2:0], manual in [10:8]
	localparam int STAT_CUR_LSB  = 0;
	localparam int STAT_MAN_LSB  = 8;
	localparam logic [CTX_W-1:0] LEVEL_MIN = 3'h1;
	localparam logic [CTX_W-1:0] LEVEL_MAX = 3'h6;
	localparam logic [CTX_W-1:0] CTX_PRIMARY = 3'h0;
	localparam logic [CTX_W-1:0] CTX_ALT1    = 3'h1;
	localparam logic [CTX_W-1:0] CTX_LAST    = 3'h2;
	localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] PC_HIGH_W = 8'h7f;
endpackage

// file: testbench/exec_model.sv
// model of the execution unit that drives the core side of the register file
`timescale 1ns/1ps
module exec_model
	import regfile_pkg::*;
(
	// clock
	input  wire logic             clock,
	// towards the register file
	output logic [3:0]            op_index,
	output logic                  wb_en,
	output logic [3:0]            wb_index,
	output logic [DATA_W-1:0]     wb_data,
	output logic                  irq_enter,
	output logic [CTX_W-1:0]      irq_level,
	output logic                  irq_return,
	output logic                  swap_en,
	output logic [CTX_W-1:0]      swap_ctx,
	output logic                  pc_load,
	output logic [PC_W-1:0]       pc_value,
	output logic                  pc_step,
	output logic                  loop_start_load,
	output logic [PC_W-1:0]       loop_start_value,
	output logic                  acc_load,
	output logic                  acc_sel,
	output logic [ACC_W-1:0]      acc_value
);
	initial
	begin
		{op_index, wb_en, wb_index, wb_data, irq_enter, irq_level, irq_return} = '0;
		{swap_en, swap_ctx, pc_load, pc_value, pc_step, loop_start_load, loop_start_value} = '0;
		{acc_load, acc_sel, acc_value} = '0;
	end
	// one command for one cycle; strobes drop at the edge that takes them
	task automatic pulse(input int kind, input logic [3:0] a, input logic [ACC_W-1:0] b);
		@(posedge clock);
		case (kind)
			0: {wb_en, wb_index, wb_data} <= {1'b1, a, b[15:0]};
			1: {irq_enter, irq_level} <= {1'b1, a[2:0]};
			2: irq_return <= 1'b1;
			3: {swap_en, swap_ctx} <= {1'b1, a[2:0]};
			4: {pc_load, pc_value} <= {1'b1, b[22:0]};
			5: {loop_start_load, loop_start_value} <= {1'b1, b[22:0]};
			6: {acc_load, acc_sel, acc_value} <= {1'b1, a[0], b};
			8: pc_step <= 1'b1;
			default: op_index <= a;
		endcase
		@(posedge clock);
		{wb_en, irq_enter, irq_return, swap_en, pc_load, pc_step, loop_start_load, acc_load} <= '0;
	endtask
endmodule

// file: testbench/cpu_register_file_contexts_tb_top.sv
// self-checking bench for the register file with alternate contexts
`timescale 1ns/1ps
module cpu_register_file_contexts_tb_top;
	import regfile_pkg::*;
	logic clock = 1'b0, reset = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, op_data, sp;
	logic [3:0] op_index, wb_index;
	logic [DATA_W-1:0] wb_data;
	logic wb_en, irq_enter, irq_return, swap_en, pc_load, loop_start_load, acc_load, acc_sel;
	logic pc_step;
	logic [CTX_W-1:0] irq_level, swap_ctx, cur, man;
	logic [PC_W-1:0] pc_value, loop_start_value, pc_out;
	logic [ACC_W-1:0] acc_value, acc1, acc2;
	int n_mismatch = 0, compares = 0, cyc = 0;
	integer seed = 32'ha5ea;
	always #12.5 clock = ~clock;
	exec_model eu (.clock(clock), .op_index(op_index), .wb_en(wb_en), .wb_index(wb_index),
		.wb_data(wb_data), .irq_enter(irq_enter), .irq_level(irq_level),
		.irq_return(irq_return), .swap_en(swap_en), .swap_ctx(swap_ctx), .pc_load(pc_load),
		.pc_value(pc_value), .pc_step(pc_step), .loop_start_load(loop_start_load),
		.loop_start_value(loop_start_value), .acc_load(acc_load), .acc_sel(acc_sel),
		.acc_value(acc_value));
	regfile_core uut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
		.write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
		.op_index(op_index), .op_data(op_data), .wb_en(wb_en), .wb_index(wb_index),
		.wb_data(wb_data), .irq_enter(irq_enter), .irq_level(irq_level),
		.irq_return(irq_return), .swap_en(swap_en), .swap_ctx(swap_ctx), .pc_load(pc_load),
		.pc_value(pc_value), .pc_step(pc_step), .loop_start_load(loop_start_load),
		.loop_start_value(loop_start_value), .acc_load(acc_load), .acc_sel(acc_sel),
		.acc_value(acc_value), .current_context_index(cur), .manual_context_index(man),
		.stack_pointer_register(sp), .pc_out(pc_out), .accumulator_first(acc1),
		.accumulator_second(acc2));
	// ****************************************
	// bus tasks and checks
	// ****************************************
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		{addr, wdata, write_strobe} <= {a, d, 1'b1};
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [ACC_W-1:0] r);
		@(posedge clock);
		{addr, read_strobe} <= {a, 1'b1};
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 r = 40'(rdata);
	endtask
	task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [CTX_W-1:0] exp_ctx(input int lvl);
		return (lvl == 3) ? 3'h1 : (lvl == 5) ? 3'h2 : CTX_PRIMARY;
	endfunction
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			close_out;
		end
	end
	initial
	begin
		logic [ACC_W-1:0] r, av;
		logic [DATA_W-1:0] v [16];
		logic [DATA_W-1:0] w3;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		rd(ADDR_CTX_STAT, r);
		chk(r, 40'h0);
		chk(40'(cur), 40'(CTX_PRIMARY));
		$display("test reset done");
		for (int i = 0; i < 16; i++)
		begin
			v[i] = 16'($random(seed));
			wr(ADDR_W0 + 8'(i * 4), v[i]);
		end
		for (int i = 0; i < 16; i++)
		begin
			rd(ADDR_W0 + 8'(i * 4), r);
			chk(r, 40'(v[i]));
		end
		chk(40'(sp), 40'(v[15]));
		eu.pulse(7, 4'hf, '0);
		#1 chk(40'(op_data), 40'(v[15]));
		$display("test primary array done");
		wr(ADDR_CTX_SWAP, 16'h0001);
		#1 chk(40'({man, cur}), 40'h9);
		rd(ADDR_CTX_STAT, r);
		chk(r, 40'h101);
		rd(ADDR_W0 + 8'h0c, r);
		chk(r, 40'h0);
		w3 = ~v[3];
		eu.pulse(0, 4'h3, 40'(w3));
		rd(ADDR_W0 + 8'h0c, r);
		chk(r, 40'(w3));
		rd(ADDR_SP, r);
		chk(r, 40'(v[15]));
		eu.pulse(3, 4'h0, '0);
		rd(ADDR_W0 + 8'h0c, r);
		chk(r, 40'(v[3]));
		rd(ADDR_CTX_STAT, r);
		chk(r, 40'h0);
		eu.pulse(3, 4'h7, '0);
		#1 chk(40'({man, cur}), 40'h0);
		wr(ADDR_CTX_SWAP, 16'h0003);
		#1 chk(40'({man, cur}), 40'h0);
		$display("test manual swap done");
		wr(ADDR_ALT_CFG, 16'h0053);
		rd(ADDR_ALT_CFG, r);
		chk(r, 40'h53);
		for (int l = 0; l < 8; l++)
		begin
			eu.pulse(1, 4'(l), '0);
			#1 chk(40'(cur), 40'(exp_ctx(l)));
			eu.pulse(2, 4'h0, '0);
			#1 chk(40'(cur), 40'(CTX_PRIMARY));
		end
		$display("test priority binding done");
		av = 40'({$random(seed), $random(seed)});
		eu.pulse(0, 4'hf, av);
		#1 chk(40'(sp), 40'(av[15:0]));
		fork
			wr(ADDR_W0 + 8'h08, 16'h1234);
			eu.pulse(0, 4'h2, 40'h5678);
		join
		rd(ADDR_W0 + 8'h08, r);
		chk(r, 40'h1234);
		eu.pulse(5, 4'h0, av);
		wr(ADDR_LOOP_SL, ~av[15:0]);
		wr(ADDR_LOOP_SH, ~av[31:16]);
		rd(ADDR_LOOP_SL, r);
		chk(r, 40'(av[15:0]));
		rd(ADDR_LOOP_SH, r);
		chk(r, 40'(av[22:16]));
		eu.pulse(4, 4'h0, av);
		rd(ADDR_PC_H, r);
		chk(r, 40'(av[22:16]));
		chk(40'(pc_out), 40'(av[22:0]));
		eu.pulse(8, 4'h0, '0);
		#1 chk(40'(pc_out), 40'(23'(av[22:0] + 23'h1)));
		for (int s = 0; s < 2; s++)
		begin
			av = 40'({$random(seed), $random(seed)});
			eu.pulse(6, 4'(s), av);
			rd((s == 0) ? ADDR_ACC1_U : ADDR_ACC2_U, r);
			chk(r, 40'(av[39:32]));
			chk((s == 0) ? acc1 : acc2, av);
		end
		rd(8'hfc, r);
		chk(r, 40'h0);
		$display("test loop pc accumulators done");
		close_out;
	end
endmodule
